// ---- src/usdp_top.sv ----
// Shadow receive/transmit data port of a UART with AXI4-Lite registers
//
// The AXI4-Lite slave port was decided locally.
module usdp_top
  import usdp_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [31:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [31:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic SIN,
  input wire logic SIR_IN,
  output logic SOUT,
  output logic SIR_OUT_N
);
  typedef struct packed {
    logic aw_got;
    logic [31:0] aw_addr;
    logic w_got;
    logic [7:0] w_data;
    logic w_strb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [15:0] rdata;
    logic fifo_en;
    logic ir_mode;
    logic [7:0] receive_buffer_reg;
    logic rbr_valid;
    logic overrun;
    logic [7:0] transmit_holding_reg;
    logic thr_valid;
    logic [2:0] sin_sync;
    logic sin_line;
    logic [2:0] sir_sync;
    logic sir_line;
    logic [7:0] tick_cnt;
    logic tick;
    logic [3:0] ir_hold;
    logic ir_active;
    usdp_ser_e rx_state;
    logic [3:0] rx_ovs;
    logic [2:0] rx_bit;
    logic [7:0] rx_shift;
    usdp_ser_e tx_state;
    logic [3:0] tx_ovs;
    logic [2:0] tx_bit;
    logic [7:0] tx_shift;
    logic sout;
    logic sir_out_n;
  } usdp_state_s;

  usdp_state_s st_ff;
  usdp_state_s nxt_st;

  logic rd_go;
  logic wr_go;
  logic rxf_in_valid;
  logic rxf_in_ready;
  logic rxf_out_valid;
  logic rxf_out_ready;
  logic [7:0] rxf_out_data;
  logic txf_in_valid;
  logic txf_in_ready;
  logic txf_out_valid;
  logic txf_out_ready;
  logic [7:0] txf_out_data;
  logic skid_in_valid;
  logic skid_in_ready;
  logic [7:0] skid_in_data;
  logic skid_out_valid;
  logic skid_out_ready;
  logic [7:0] skid_out_data;
  logic fifo_flush;
  logic thr_empty;
  logic tx_idle;

  assign S_AXI_AWREADY = !st_ff.aw_got && !st_ff.bvalid;
  assign S_AXI_WREADY = !st_ff.w_got && !st_ff.bvalid;
  assign S_AXI_ARREADY = !st_ff.rvalid;
  assign S_AXI_BVALID = st_ff.bvalid;
  assign S_AXI_BRESP = st_ff.bresp;
  assign S_AXI_RVALID = st_ff.rvalid;
  assign S_AXI_RRESP = st_ff.rresp;
  assign S_AXI_RDATA = {16'h0000, st_ff.rdata};
  assign SOUT = st_ff.sout;
  assign SIR_OUT_N = st_ff.sir_out_n;

  assign rd_go = S_AXI_ARVALID && !st_ff.rvalid;
  assign wr_go = st_ff.aw_got && st_ff.w_got;
  assign thr_empty = st_ff.fifo_en ? !txf_out_valid : !st_ff.thr_valid;
  assign tx_idle = thr_empty && !skid_out_valid && (st_ff.tx_state == SER_IDLE);

  // Transmit source feeds the two-entry buffer in front of the serializer
  assign skid_in_valid = st_ff.fifo_en ? txf_out_valid : st_ff.thr_valid;
  assign skid_in_data = st_ff.fifo_en ? txf_out_data : st_ff.transmit_holding_reg;
  assign txf_out_ready = st_ff.fifo_en && skid_in_ready;
  assign skid_out_ready = (st_ff.tx_state == SER_IDLE);

  always_comb begin
    logic rx_done;
    logic rx_in;
    logic tx_level;
    logic [7:0] rx_byte;
    rx_done = 1'h0;
    rx_in = 1'h1;
    tx_level = 1'h1;
    rx_byte = 8'h00;
    nxt_st = st_ff;
    rxf_in_valid = 1'h0;
    rxf_out_ready = 1'h0;
    txf_in_valid = 1'h0;
    fifo_flush = 1'h0;

    // Pin synchronisers and bit-rate oversampling tick
    nxt_st.sin_sync = {st_ff.sin_sync[1:0], SIN};
    nxt_st.sir_sync = {st_ff.sir_sync[1:0], SIR_IN};
    if (st_ff.sin_sync[1] == st_ff.sin_sync[2]) begin
      nxt_st.sin_line = st_ff.sin_sync[2];
    end
    if (st_ff.sir_sync[1] == st_ff.sir_sync[2]) begin
      nxt_st.sir_line = st_ff.sir_sync[2];
    end
    nxt_st.tick = (st_ff.tick_cnt == TICK_LAST);
    nxt_st.tick_cnt = nxt_st.tick ? 8'h00 : st_ff.tick_cnt + 8'h01;

    if (st_ff.sir_line) begin
      nxt_st.ir_hold = OVS_LAST;
      nxt_st.ir_active = 1'h1;
    end else if (st_ff.tick) begin
      if (st_ff.ir_hold != 4'h0) begin
        nxt_st.ir_hold = st_ff.ir_hold - 4'h1;
      end else begin
        nxt_st.ir_active = 1'h0;
      end
    end
    rx_in = st_ff.ir_mode ? !st_ff.ir_active : st_ff.sin_line;

    // Receiver
    if (st_ff.tick) begin
      nxt_st.rx_ovs = st_ff.rx_ovs + 4'h1;
      unique case (st_ff.rx_state)
        SER_IDLE: begin
          nxt_st.rx_ovs = 4'h0;
          if (!rx_in) begin
            nxt_st.rx_state = SER_START;
          end
        end
        SER_START: begin
          if (st_ff.rx_ovs == OVS_MID) begin
            nxt_st.rx_ovs = 4'h0;
            nxt_st.rx_bit = 3'h0;
            nxt_st.rx_state = rx_in ? SER_IDLE : SER_DATA;
          end
        end
        SER_DATA: begin
          if (st_ff.rx_ovs == OVS_LAST) begin
            nxt_st.rx_shift = {rx_in, st_ff.rx_shift[7:1]};
            nxt_st.rx_bit = st_ff.rx_bit + 3'h1;
            if (st_ff.rx_bit == LAST_DATA_BIT) begin
              nxt_st.rx_state = SER_STOP;
            end
          end
        end
        SER_STOP: begin
          if (st_ff.rx_ovs == OVS_LAST) begin
            rx_done = 1'h1;
            nxt_st.rx_state = SER_IDLE;
          end
        end
      endcase
    end

    // Transmit holding register drains into the buffer
    if (!st_ff.fifo_en && st_ff.thr_valid && skid_in_ready) begin
      nxt_st.thr_valid = 1'h0;
    end

    if (st_ff.tx_state == SER_IDLE) begin
      if (skid_out_valid) begin
        nxt_st.tx_shift = skid_out_data;
        nxt_st.tx_ovs = 4'h0;
        nxt_st.tx_state = SER_START;
      end
    end else if (st_ff.tick) begin
      nxt_st.tx_ovs = st_ff.tx_ovs + 4'h1;
      if (st_ff.tx_ovs == OVS_LAST) begin
        unique case (st_ff.tx_state)
          SER_START: begin
            nxt_st.tx_bit = 3'h0;
            nxt_st.tx_state = SER_DATA;
          end
          SER_DATA: begin
            nxt_st.tx_shift = {1'h0, st_ff.tx_shift[7:1]};
            nxt_st.tx_bit = st_ff.tx_bit + 3'h1;
            if (st_ff.tx_bit == LAST_DATA_BIT) begin
              nxt_st.tx_state = SER_STOP;
            end
          end
          default: nxt_st.tx_state = SER_IDLE;
        endcase
      end
    end
    unique case (st_ff.tx_state)
      SER_START: tx_level = 1'h0;
      SER_DATA: tx_level = st_ff.tx_shift[0];
      default: tx_level = 1'h1;
    endcase
    // output by mode, IR active low
    nxt_st.sout = st_ff.ir_mode ? 1'h1 : tx_level;
    nxt_st.sir_out_n = !(st_ff.ir_mode && !tx_level && (st_ff.tx_ovs < IR_PULSE_TICKS));

    // Write address and data are taken in either order
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      nxt_st.aw_got = 1'h1;
      nxt_st.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      nxt_st.w_got = 1'h1;
      nxt_st.w_data = S_AXI_WDATA[7:0];
      nxt_st.w_strb0 = S_AXI_WSTRB[0];
    end
    if (st_ff.bvalid && S_AXI_BREADY) begin
      nxt_st.bvalid = 1'h0;
    end
    if (st_ff.rvalid && S_AXI_RREADY) begin
      nxt_st.rvalid = 1'h0;
    end

    // Read side effects
    if (rd_go) begin
      nxt_st.rvalid = 1'h1;
      nxt_st.rresp = RESP_OKAY;
      nxt_st.rdata = 16'h0000;
      if (usdp_is_data_addr(S_AXI_ARADDR)) begin
        if (st_ff.fifo_en) begin
          rx_byte = rxf_out_valid ? rxf_out_data : 8'h00;
          rxf_out_ready = 1'h1;
        end else begin
          rx_byte = st_ff.receive_buffer_reg;
          nxt_st.rbr_valid = 1'h0;
        end
        nxt_st.rdata = {8'h00, rx_byte};
      end else if (S_AXI_ARADDR == CTRL_ADDR) begin
        nxt_st.rdata[CTRL_FIFO_EN_BIT] = st_ff.fifo_en;
        nxt_st.rdata[CTRL_IR_MODE_BIT] = st_ff.ir_mode;
      end else if (S_AXI_ARADDR == LINE_STAT_ADDR) begin
        nxt_st.rdata[LS_DATA_READY_BIT] = st_ff.fifo_en ? rxf_out_valid : st_ff.rbr_valid;
        nxt_st.rdata[LS_OVERRUN_BIT] = st_ff.overrun;
        nxt_st.rdata[LS_THR_EMPTY_BIT] = thr_empty;
        nxt_st.rdata[LS_TX_IDLE_BIT] = tx_idle;
        nxt_st.overrun = 1'h0;
      end else begin
        nxt_st.rresp = RESP_DECERR;
      end
    end

    // Write commit once both halves are held
    if (wr_go) begin
      nxt_st.aw_got = 1'h0;
      nxt_st.w_got = 1'h0;
      nxt_st.bvalid = 1'h1;
      nxt_st.bresp = RESP_OKAY;
      if (usdp_is_data_addr(st_ff.aw_addr)) begin
        if (st_ff.w_strb0) begin
          if (st_ff.fifo_en) begin
            txf_in_valid = 1'h1;
          end else begin
            nxt_st.transmit_holding_reg = st_ff.w_data;
            nxt_st.thr_valid = 1'h1;
          end
        end
      end else if (st_ff.aw_addr == CTRL_ADDR) begin
        if (st_ff.w_strb0) begin
          nxt_st.fifo_en = st_ff.w_data[CTRL_FIFO_EN_BIT];
          nxt_st.ir_mode = st_ff.w_data[CTRL_IR_MODE_BIT];
          if (st_ff.w_data[CTRL_FIFO_EN_BIT] != st_ff.fifo_en) begin
            fifo_flush = 1'h1;
            nxt_st.rbr_valid = 1'h0;
            nxt_st.thr_valid = 1'h0;
          end
        end
      end else if (st_ff.aw_addr != LINE_STAT_ADDR) begin
        nxt_st.bresp = RESP_DECERR;
      end
    end

    // Character arrival; a new overrun wins over a clear by read
    if (rx_done && !fifo_flush) begin
      if (st_ff.fifo_en) begin
        rxf_in_valid = 1'h1;
        if (!rxf_in_ready) begin
          nxt_st.overrun = 1'h1;
        end
      end else begin
        if (st_ff.rbr_valid && !(rd_go && usdp_is_data_addr(S_AXI_ARADDR))) begin
          nxt_st.overrun = 1'h1;
        end
        nxt_st.receive_buffer_reg = st_ff.rx_shift;
        nxt_st.rbr_valid = 1'h1;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      st_ff <= '0;
      st_ff.receive_buffer_reg <= DATA_RESET;
      st_ff.transmit_holding_reg <= DATA_RESET;
      st_ff.fifo_en <= CTRL_FIFO_EN_RESET;
      st_ff.ir_mode <= CTRL_IR_MODE_RESET;
      st_ff.sin_sync <= PIN_SYNC_IDLE;
      st_ff.sin_line <= 1'h1;
      st_ff.sout <= 1'h1;
      st_ff.sir_out_n <= 1'h1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  usdp_fifo #(.WIDTH(CHAR_W), .DEPTH(RX_FIFO_DEPTH)) u_rx_fifo (
    .CLK(CLK),
    .SYS_RST(SYS_RST),
    .flush(fifo_flush),
    .in_valid(rxf_in_valid),
    .in_ready(rxf_in_ready),
    .in_data(st_ff.rx_shift),
    .out_valid(rxf_out_valid),
    .out_ready(rxf_out_ready),
    .out_data(rxf_out_data)
  );

  usdp_fifo #(.WIDTH(CHAR_W), .DEPTH(TX_FIFO_DEPTH)) u_tx_fifo (
    .CLK(CLK),
    .SYS_RST(SYS_RST),
    .flush(fifo_flush),
    .in_valid(txf_in_valid),
    .in_ready(txf_in_ready),
    .in_data(st_ff.w_data),
    .out_valid(txf_out_valid),
    .out_ready(txf_out_ready),
    .out_data(txf_out_data)
  );

  usdp_fifo #(.WIDTH(CHAR_W), .DEPTH(SKID_DEPTH)) u_tx_skid (
    .CLK(CLK),
    .SYS_RST(SYS_RST),
    .flush(1'h0),
    .in_valid(skid_in_valid),
    .in_ready(skid_in_ready),
    .in_data(skid_in_data),
    .out_valid(skid_out_valid),
    .out_ready(skid_out_ready),
    .out_data(skid_out_data)
  );
endmodule

// ---- src/usdp_pkg.sv ----
// Constants, types and decode helpers of the shadow data port block
package usdp_pkg;
  localparam logic [31:0] DATA_BASE_ADDR = 32'h5000_1130;
  localparam logic [31:0] DATA_REG13_ADDR = 32'h5000_1164;
  localparam int DATA_ALIAS_CNT = 16;
  localparam logic [31:0] DATA_LAST_ADDR = DATA_BASE_ADDR + 32'(4 * (DATA_ALIAS_CNT - 1));
  localparam logic [31:0] CTRL_ADDR = 32'h5000_1200;
  localparam logic [31:0] LINE_STAT_ADDR = 32'h5000_1204;
  localparam int CTRL_FIFO_EN_BIT = 0;
  localparam int CTRL_IR_MODE_BIT = 4;
  localparam int LS_DATA_READY_BIT = 0;
  localparam int LS_OVERRUN_BIT = 1;
  localparam int LS_THR_EMPTY_BIT = 5;
  localparam int LS_TX_IDLE_BIT = 6;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic CTRL_FIFO_EN_RESET = 1'h0;
  localparam logic CTRL_IR_MODE_RESET = 1'h0;
  localparam logic [2:0] PIN_SYNC_IDLE = 3'h7;
  localparam int CHAR_W = 8;
  localparam int TX_FIFO_DEPTH = 16;
  localparam int RX_FIFO_DEPTH = 16;
  localparam int SKID_DEPTH = 2;
  localparam int CLK_HZ = 125_000_000;
  localparam int BAUD_RATE = 115_200;
  localparam int OVS = 16;
  localparam int TICK_CYCLES = CLK_HZ / (BAUD_RATE * OVS);
  localparam logic [7:0] TICK_LAST = 8'(TICK_CYCLES - 1);
  localparam logic [3:0] OVS_LAST = 4'(OVS - 1);
  localparam logic [3:0] OVS_MID = 4'(OVS / 2 - 1);
  localparam logic [3:0] IR_PULSE_TICKS = 4'h3;
  localparam logic [2:0] LAST_DATA_BIT = 3'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    SER_IDLE = 2'h0,
    SER_START = 2'h1,
    SER_DATA = 2'h3,
    SER_STOP = 2'h2
  } usdp_ser_e;

  function automatic logic usdp_is_data_addr(input logic [31:0] addr);
    return (addr >= DATA_BASE_ADDR) && (addr <= DATA_LAST_ADDR) && (addr[1:0] == 2'h0);
  endfunction
endpackage

// ---- src/usdp_fifo.sv ----
// Flip-flop FIFO with valid and ready on both sides
module usdp_fifo
  import usdp_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] rd_ptr;
    logic [PW-1:0] wr_ptr;
    logic [PW:0] count;
  } usdp_fifo_s;

  usdp_fifo_s st_ff;
  usdp_fifo_s nxt_st;
  logic push;
  logic pop;

  assign in_ready = (st_ff.count != (PW + 1)'(DEPTH));
  assign out_valid = (st_ff.count != '0);
  assign out_data = st_ff.mem[st_ff.rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem[st_ff.wr_ptr] = in_data;
      nxt_st.wr_ptr = st_ff.wr_ptr + 1'h1;
    end
    if (pop) begin
      nxt_st.rd_ptr = st_ff.rd_ptr + 1'h1;
    end
    unique case ({push, pop})
      2'h2: nxt_st.count = st_ff.count + 1'h1;
      2'h1: nxt_st.count = st_ff.count - 1'h1;
      default: ;
    endcase
    if (flush) begin
      nxt_st.rd_ptr = '0;
      nxt_st.wr_ptr = '0;
      nxt_st.count = '0;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule

// ---- sim/usdp_top_asserts.sv ----
// Pin-level checks of the shadow data port
module usdp_asserts
  import usdp_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [31:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic [31:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  input wire logic SOUT,
  input wire logic SIR_OUT_N
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  sequence s_wr_take;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence s_resp;
    !S_AXI_BVALID ##1 S_AXI_BVALID;
  endsequence
  sequence s_rd_take;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  property p_wr_ans;
    s_wr_take |=> s_resp;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
  property p_wr_unmap;
    s_wr_take ##0 (S_AXI_AWADDR < DATA_BASE_ADDR) |=> s_resp ##0 (S_AXI_BRESP == RESP_DECERR);
  endproperty
  a_wr_unmap: assert property (p_wr_unmap) else $error("unmapped write ok");
  property p_rd_ok;
    s_rd_take ##0 (S_AXI_ARADDR >= DATA_BASE_ADDR && S_AXI_ARADDR <= DATA_LAST_ADDR
      && S_AXI_ARADDR[1:0] == 2'h0)
      |=> S_AXI_RVALID && S_AXI_RRESP == RESP_OKAY;
  endproperty
  a_rd_ok: assert property (p_rd_ok) else $error("alias read bad");
  property p_rd_unmap;
    s_rd_take ##0 (S_AXI_ARADDR < DATA_BASE_ADDR)
      |=> S_AXI_RVALID && S_AXI_RRESP == RESP_DECERR && S_AXI_RDATA == 32'h0;
  endproperty
  a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read ok");
  property p_upper;
    S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0;
  endproperty
  a_upper: assert property (p_upper) else $error("upper bits set");
  property p_b_busy;
    S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY;
  endproperty
  a_b_busy: assert property (p_b_busy) else $error("write taken early");
  property p_rd_busy;
    S_AXI_RVALID |-> !S_AXI_ARREADY;
  endproperty
  a_rd_busy: assert property (p_rd_busy) else $error("read taken early");
  property p_pins;
    SOUT || SIR_OUT_N;
  endproperty
  a_pins: assert property (p_pins) else $error("both outputs active");
  property p_start;
    $fell(SOUT) |-> (!SOUT) [*8];
  endproperty
  a_start: assert property (p_start) else $error("start bit short");
  property p_idle;
    $fell(SYS_RST) |-> SOUT && SIR_OUT_N && !S_AXI_RVALID && !S_AXI_BVALID;
  endproperty
  a_idle: assert property (p_idle) else $error("not idle after reset");
endmodule

// ---- sim/usdp_peer.sv ----
// Remote serial transceiver: sends on the line or infrared pins, receives on the line pin only
module usdp_peer
  import usdp_pkg::*;
(
  input wire logic CLK,
  input wire logic SOUT,
  output logic SIN,
  output logic SIR_IN
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT_CYC = TICK_CYCLES * OVS;
  localparam int IR_CYC = int'(IR_PULSE_TICKS) * TICK_CYCLES;
  initial begin
    SIN = 1'b1;
    SIR_IN = 1'b0;
  end
  // Frame out: start, eight bits low first, stop
  task automatic send(input logic [7:0] b, input logic ir);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge CLK);
      if (ir) begin
        SIR_IN <= ~f[i];
        repeat (IR_CYC) @(posedge CLK);
        SIR_IN <= 1'b0;
        repeat (BIT_CYC - IR_CYC - 1) @(posedge CLK);
      end else begin
        SIN <= f[i];
        repeat (BIT_CYC - 1) @(posedge CLK);
      end
    end
  endtask
  // Sample each bit at its middle
  task automatic recv(output logic [7:0] b);
    do @(posedge CLK); while (SOUT !== 1'b0);
    repeat (BIT_CYC / 2) @(posedge CLK);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge CLK);
      b[i] = SOUT;
    end
    repeat (BIT_CYC) @(posedge CLK);
  endtask
endmodule

// ---- sim/test_uart_shadow_data_port.sv ----
// Self-checking bench of the shadow data port
module test_uart_shadow_data_port
  import usdp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] LS_IDLE = (32'h1 << LS_THR_EMPTY_BIT) | (32'h1 << LS_TX_IDLE_BIT);
  localparam logic [31:0] LS_DR = 32'h1 << LS_DATA_READY_BIT;
  localparam logic [31:0] LS_OVR = 32'h1 << LS_OVERRUN_BIT;
  localparam logic [31:0] FIFO_IR = (32'h1 << CTRL_FIFO_EN_BIT) | (32'h1 << CTRL_IR_MODE_BIT);
  localparam logic [31:0] NO_ADDR = 32'h0000_0100;
  localparam logic [31:0] IR_ONLY = 32'h1 << CTRL_IR_MODE_BIT;
  localparam int BIT_CYC = TICK_CYCLES * OVS;
  logic CLK, SYS_RST, SIN, SIR_IN, SOUT, SIR_OUT_N;
  logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
  logic S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
  logic [31:0] S_AXI_AWADDR, S_AXI_WDATA, S_AXI_ARADDR, S_AXI_RDATA;
  logic [3:0] S_AXI_WSTRB;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  int failures = 0;
  int comparisons = 0;
  usdp_top u_usdp_top (.CLK, .SYS_RST, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
    .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
    .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
    .S_AXI_RVALID, .S_AXI_RREADY, .SIN, .SIR_IN, .SOUT, .SIR_OUT_N);
  usdp_peer u_peer (.CLK, .SOUT, .SIN, .SIR_IN);
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wchk(input string what, input logic [31:0] a, input logic [31:0] d,
      input logic [1:0] er);
    @(posedge CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    fork
      begin
        do @(posedge CLK); while (S_AXI_AWREADY !== 1'b1);
        S_AXI_AWVALID <= 1'b0;
      end
      begin
        do @(posedge CLK); while (S_AXI_WREADY !== 1'b1);
        S_AXI_WVALID <= 1'b0;
      end
    join
    while (S_AXI_BVALID !== 1'b1) @(posedge CLK);
    S_AXI_BREADY <= 1'b0;
    chk(what, {30'h0, S_AXI_BRESP}, {30'h0, er});
  endtask
  task automatic rchk(input string what, input logic [31:0] a, input logic [31:0] e,
      input logic [1:0] er);
    @(posedge CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do @(posedge CLK); while (S_AXI_ARREADY !== 1'b1);
    S_AXI_ARVALID <= 1'b0;
    while (S_AXI_RVALID !== 1'b1) @(posedge CLK);
    S_AXI_RREADY <= 1'b0;
    chk(what, S_AXI_RDATA, e);
    chk(what, {30'h0, S_AXI_RRESP}, {30'h0, er});
  endtask
  task automatic t_reset;
    rchk("data at reset", DATA_REG13_ADDR, 32'h0, RESP_OKAY);
    rchk("status at reset", LINE_STAT_ADDR, LS_IDLE, RESP_OKAY);
    rchk("unmapped read", NO_ADDR, 32'h0, RESP_DECERR);
    wchk("unmapped write", NO_ADDR, 32'h5A, RESP_DECERR);
    wchk("status write", LINE_STAT_ADDR, 32'h0, RESP_OKAY);
    S_AXI_WSTRB <= 4'h0;
    wchk("lane off write", DATA_REG13_ADDR, 32'hA5, RESP_OKAY);
    S_AXI_WSTRB <= 4'hF;
    rchk("status kept", LINE_STAT_ADDR, LS_IDLE, RESP_OKAY);
  endtask
  task automatic t_rx_plain;
    u_peer.send(8'h3C, 1'b0);
    u_peer.send(8'h5A, 1'b0);
    rchk("status overrun", LINE_STAT_ADDR, LS_IDLE | LS_DR | LS_OVR, RESP_OKAY);
    rchk("newest char", DATA_REG13_ADDR, 32'h5A, RESP_OKAY);
    rchk("status clear", LINE_STAT_ADDR, LS_IDLE, RESP_OKAY);
  endtask
  task automatic t_rx_fifo_ir;
    wchk("fifo ir on", CTRL_ADDR, FIFO_IR, RESP_OKAY);
    u_peer.send(8'h96, 1'b1);
    u_peer.send(8'h69, 1'b1);
    rchk("status ready", LINE_STAT_ADDR, LS_IDLE | LS_DR, RESP_OKAY);
    rchk("fifo head", DATA_BASE_ADDR, 32'h96, RESP_OKAY);
    rchk("fifo next", DATA_LAST_ADDR, 32'h69, RESP_OKAY);
    rchk("fifo empty", LINE_STAT_ADDR, LS_IDLE, RESP_OKAY);
    wchk("fifo ir off", CTRL_ADDR, 32'h0, RESP_OKAY);
  endtask
  task automatic t_tx;
    logic [7:0] got [4];
    logic [7:0] exp [4] = '{8'hC1, 8'hC2, 8'hC3, 8'hC5};
    fork
      for (int i = 0; i < 4; i++) u_peer.recv(got[i]);
      begin
        wchk("tx one", DATA_BASE_ADDR, 32'h0000_FFC1, RESP_OKAY);
        wchk("tx two", DATA_REG13_ADDR, 32'hC2, RESP_OKAY);
        wchk("tx three", DATA_LAST_ADDR, 32'hC3, RESP_OKAY);
        wchk("tx four", DATA_REG13_ADDR, 32'hC4, RESP_OKAY);
        rchk("holding full", LINE_STAT_ADDR, 32'h0, RESP_OKAY);
        wchk("tx five", DATA_REG13_ADDR, 32'hC5, RESP_OKAY);
      end
    join
    for (int i = 0; i < 4; i++) chk("sent char", {24'h0, got[i]}, {24'h0, exp[i]});
  endtask
  // Infrared transmit: short low pulse for each zero bit, line output held high
  task automatic t_tx_ir;
    wchk("ir on", CTRL_ADDR, IR_ONLY, RESP_OKAY);
    rchk("ctrl read", CTRL_ADDR, IR_ONLY, RESP_OKAY);
    wchk("ir char", DATA_REG13_ADDR, 32'hFE, RESP_OKAY);
    do @(posedge CLK); while (SIR_OUT_N !== 1'b0);
    repeat (TICK_CYCLES) @(posedge CLK);
    chk("ir start pulse", {31'h0, SIR_OUT_N}, 32'h0);
    repeat (3 * TICK_CYCLES) @(posedge CLK);
    chk("ir pulse end", {31'h0, SIR_OUT_N}, 32'h1);
    repeat (BIT_CYC - 3 * TICK_CYCLES) @(posedge CLK);
    chk("ir zero bit", {31'h0, SIR_OUT_N}, 32'h0);
    chk("line held high", {31'h0, SOUT}, 32'h1);
    repeat (BIT_CYC) @(posedge CLK);
    chk("ir one bit", {31'h0, SIR_OUT_N}, 32'h1);
  endtask
  task automatic conclude;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge CLK);
    failures++;
    conclude();
  end
  initial begin
    SYS_RST = 1'b1;
    S_AXI_AWADDR = 32'h0;
    S_AXI_AWVALID = 1'b0;
    S_AXI_WDATA = 32'h0;
    S_AXI_WSTRB = 4'hF;
    S_AXI_WVALID = 1'b0;
    S_AXI_BREADY = 1'b0;
    S_AXI_ARADDR = 32'h0;
    S_AXI_ARVALID = 1'b0;
    S_AXI_RREADY = 1'b0;
    repeat (12) @(posedge CLK);
    SYS_RST <= 1'b0;
    t_reset();
    t_rx_plain();
    t_rx_fifo_ir();
    t_tx();
    t_tx_ir();
    conclude();
  end
endmodule
bind usdp_top usdp_asserts u_usdp_asserts (.CLK, .SYS_RST, .S_AXI_AWADDR, .S_AXI_AWVALID,
  .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_ARADDR,
  .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .SOUT,
  .SIR_OUT_N);
